// ### hw/mra_pkg.sv
// Shared constants, types and helpers of the robot address-map decoder.
// Assumes a parser upstream that splits each Modbus frame into items.
`default_nettype none
package mra_pkg;
  // Function codes, hex values
  localparam logic [7:0] FC_RD_COIL = 8'h01;
  localparam logic [7:0] FC_RD_DI = 8'h02;
  localparam logic [7:0] FC_RD_HR = 8'h03;
  localparam logic [7:0] FC_RD_IR = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_HR = 8'h06;
  localparam logic [7:0] FC_WR_COILS = 8'h0f;
  localparam logic [7:0] FC_WR_HRS = 8'h10;
  localparam logic [7:0] FC_MASK_HR = 8'h16;
  localparam logic [7:0] FC_RW_HRS = 8'h17;
  // Standard exception codes
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  // Single coil write values
  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  // Bit addresses
  localparam logic [15:0] B_HAS_LO = 16'h000a;
  localparam logic [15:0] B_HAS_HI = 16'h000e;
  localparam logic [15:0] B_MOD_OK = 16'h0014;
  localparam logic [15:0] B_MOD_LO = 16'h0015;
  localparam logic [15:0] B_MOD_HI = 16'h001e;
  localparam logic [15:0] B_KIN_OK = 16'h0025;
  localparam logic [15:0] B_KIN_LO = 16'h0026;
  localparam logic [15:0] B_KIN_HI = 16'h002c;
  localparam logic [15:0] B_BLK_HI = 16'h0031;
  localparam logic [15:0] C_BUS = 16'h0032;
  localparam logic [15:0] C_SHUTDOWN = 16'h0033;
  localparam logic [15:0] C_RESET = 16'h0034;
  localparam logic [15:0] C_MOTOR = 16'h0035;
  localparam logic [15:0] B_NORMAL = 16'h0036;
  localparam logic [15:0] C_REF_ALL = 16'h003c;
  localparam logic [15:0] C_REF_AX_LO = 16'h003d;
  localparam logic [15:0] C_REF_AX_HI = 16'h0042;
  localparam logic [15:0] C_REF_EX_LO = 16'h0043;
  localparam logic [15:0] C_REF_EX_HI = 16'h0045;
  // Word areas
  localparam logic [15:0] IR_MAP_VER = 16'h0003;
  localparam logic [15:0] MAP_VERSION = 16'h0001;
  localparam int HR_DEPTH = 16;
  localparam logic [15:0] HR_LIMIT = 16'h0010;
  localparam int STR_BASE = 8;
  localparam int STR_REGS = 8;
  // Rising-edge coils: shutdown, reset, all axes, six robot, three external
  localparam int N_EDGE = 12;
  localparam int E_SHUTDOWN = 0;
  localparam int E_RESET = 1;
  localparam int E_REF_ALL = 2;
  localparam int E_REF_AX = 3;
  localparam int E_REF_EX = 9;
  // Server configuration after reset
  localparam logic [15:0] TCP_PORT_DEF = 16'h01f6;
  localparam logic [7:0] MAX_CONN_DEF = 8'h04;

  typedef enum logic [2:0] {
    AREA_COIL, AREA_DI, AREA_HR, AREA_IR, AREA_NONE
  } mra_area_t;

  typedef enum logic [2:0] {
    OP_READ, OP_WR1, OP_WRN, OP_MASK, OP_RW
  } mra_op_t;

  typedef struct packed {
    logic [7:0] fc;        // Function code
    logic [15:0] addr;     // Item address
    logic [15:0] wdata;    // Write value (bit in [0] for multi-coil)
    logic [15:0] and_mask; // Masked write AND mask
    logic [15:0] or_mask;  // Masked write OR mask
  } mra_req_t;

  typedef struct packed {
    logic exc;             // Exception answer
    logic [7:0] exc_code;  // Exception code
    logic [15:0] rdata;    // Read or echoed value
  } mra_rsp_t;

  typedef struct packed {
    logic [4:0] has_mod;   // Robot, ext, gripper, platform, IO present
    logic [9:0] mod_err;   // Module error flags, temperature first
    logic [6:0] kin_err;   // Kinematics error flags, limit min first
    logic bus_conn;        // CAN bus connected
    logic motors_on;       // Motors active
    logic normal_op;       // Normal operating mode
    logic ref_all;         // All axes referenced
    logic [5:0] ref_axis;  // Robot axes referenced
    logic [2:0] ref_ext;   // External axes referenced
  } mra_stat_t;

  typedef struct packed {
    logic bus_connect;     // Connect CAN bus
    logic bus_disconnect;  // Disconnect CAN bus
    logic shutdown;        // Shut down control computer
    logic robot_reset;     // Reset robot
    logic motor_enable;    // Enable motors
    logic motor_disable;   // Disable motors
    logic ref_all;         // Reference all axes
    logic [5:0] ref_axis;  // Reference one robot axis
    logic [2:0] ref_ext;   // Reference one external axis
  } mra_act_t;

  // Address window test used by the bit read mux and coil write check
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range
endpackage : mra_pkg
`default_nettype wire

// ### hw/mra_fc_check.sv
// Function code classifier: memory area, kind of access, support.
// Assumes a purely combinational use inside the request stage.
`default_nettype none
module mra_fc_check (
  input wire logic [7:0] fc,           // Function code
  output mra_pkg::mra_area_t area,     // Area addressed
  output mra_pkg::mra_op_t op,         // Kind of access
  output logic ok                      // Code is supported
);
  import mra_pkg::*;

  // Map each supported code to its area; others are refused
  always_comb begin
    area = AREA_NONE;
    op = OP_READ;
    ok = 1'b1;
    unique case (fc)
      FC_RD_COIL: area = AREA_COIL;
      FC_WR_COIL: begin
        area = AREA_COIL;
        op = OP_WR1;
      end
      FC_WR_COILS: begin
        area = AREA_COIL;
        op = OP_WRN;
      end
      FC_RD_DI: area = AREA_DI;
      FC_RD_HR: area = AREA_HR;
      FC_WR_HR, FC_WR_HRS: begin
        area = AREA_HR;
        op = OP_WRN;
      end
      FC_MASK_HR: begin
        area = AREA_HR;
        op = OP_MASK;
      end
      FC_RW_HRS: begin
        area = AREA_HR;
        op = OP_RW;
      end
      FC_RD_IR: area = AREA_IR;
      default: ok = 1'b0;
    endcase
  end
endmodule : mra_fc_check
`default_nettype wire

// ### hw/mra_edge.sv
// Rising-edge action coils: arm on a written 0, fire on a later 1.
// Assumes at most one coil is written per clock.
`default_nettype none
module mra_edge #(
  parameter int N = 4                  // Number of coils
) (
  input wire logic clock,              // System clock
  input wire logic rst_n,              // Synchronous reset, active low
  input wire logic [N-1:0] wr_en,      // Write strobe per coil
  input wire logic wr_val,             // Bit written
  output logic [N-1:0] fire,           // One-cycle action pulse
  output logic [N-1:0] last            // Last written value
);
  logic [N-1:0] armed_q, armed_d;      // A 0 was written since last fire
  logic [N-1:0] last_q, last_d;        // Written value readback
  logic [N-1:0] fire_q, fire_d;        // Registered pulse

  // Arm and fire per coil
  always_comb begin
    armed_d = armed_q;
    last_d = last_q;
    fire_d = '0;
    for (int i = 0; i < N; i++) begin
      if (wr_en[i]) begin
        last_d[i] = wr_val;
        if (!wr_val) begin
          armed_d[i] = 1'b1;
        end else if (armed_q[i]) begin
          fire_d[i] = 1'b1;
          armed_d[i] = 1'b0;
        end
      end
    end
  end

  // State registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      armed_q <= '0;
      last_q <= '0;
      fire_q <= '0;
    end else begin
      armed_q <= armed_d;
      last_q <= last_d;
      fire_q <= fire_d;
    end
  end

  assign fire = fire_q;
  assign last = last_q;
endmodule : mra_edge
`default_nettype wire

// ### hw/mra_top.sv
// Robot address-map decoder: executes one Modbus item access per request.
// Assumes an upstream parser splitting frames into single-item requests
// and a downstream framer building the answer from each response.
`default_nettype none
module mra_top #(
  parameter bit BUS_SWITCH = 1'b1       // Variant can switch the bus
) (
  input wire logic clock,               // 20 MHz system clock
  input wire logic rst_n,               // Synchronous reset, active low
  input wire logic req_valid,           // Item request present
  output logic req_ready,               // Item request taken
  input wire mra_pkg::mra_req_t req,    // Item request
  output logic rsp_valid,               // Response present
  input wire logic rsp_ready,           // Response consumed
  output mra_pkg::mra_rsp_t rsp,        // Response
  input wire mra_pkg::mra_stat_t stat,  // Live robot state
  output mra_pkg::mra_act_t act,        // Action pulses
  output logic [15:0][15:0] hr_words,   // Holding register contents
  output logic [7:0][31:0] hr_pairs,    // Holding pairs as 32-bit
  output logic [4:0] str_len,           // Characters in string field
  input wire logic cfg_wr,              // Load server configuration
  input wire logic [15:0] cfg_port,     // New TCP port
  input wire logic [7:0] cfg_max_conn,  // New connection limit
  output logic [15:0] tcp_port,         // TCP port to listen on
  output logic [7:0] max_conn           // Simultaneous connection limit
);
  import mra_pkg::*;

  mra_area_t area;                      // Area of the current code
  mra_op_t op;                          // Access kind of current code
  logic fc_ok;                          // Current code supported
  logic take;                           // Request accepted this cycle
  logic bit_map;                        // Bit address is mapped
  logic bit_rd;                         // Bit read value
  logic coil_wr_ok;                     // Coil may be written
  logic bval;                           // Bit value being written
  logic [N_EDGE-1:0] edge_wr;           // Edge coil write strobes
  logic [N_EDGE-1:0] fire;              // Edge coil pulses
  logic [N_EDGE-1:0] last;              // Edge coil written values
  logic [15:0] hr_cur;                  // Addressed holding word
  mra_rsp_t rsp_q, rsp_d;               // Response register
  logic rsp_valid_q, rsp_valid_d;       // Response present
  mra_act_t act_q, act_d;               // Bus and motor pulses
  logic [15:0][15:0] hr_q, hr_d;        // Holding register store
  logic [4:0] str_len_q, str_len_d;     // String length
  logic [15:0] port_q, port_d;          // TCP port
  logic [7:0] conn_q, conn_d;           // Connection limit

  // Index of a rising-edge coil
  function automatic logic [3:0] edge_idx(input logic [15:0] a);
    logic [15:0] t;
    t = a - C_REF_ALL + 16'h0002;
    if (a == C_SHUTDOWN) begin
      return 4'h0;
    end
    if (a == C_RESET) begin
      return 4'h1;
    end
    return t[3:0];
  endfunction : edge_idx

  // Code classifier
  mra_fc_check u_fc (
    .fc(req.fc),
    .area(area),
    .op(op),
    .ok(fc_ok)
  );

  // Edge-triggered action coils
  mra_edge #(.N(N_EDGE)) u_edge (
    .clock(clock),
    .rst_n(rst_n),
    .wr_en(edge_wr),
    .wr_val(bval),
    .fire(fire),
    .last(last)
  );

  assign req_ready = !rsp_valid_q || rsp_ready;
  assign take = req_valid && req_ready;
  assign hr_cur = hr_q[req.addr[3:0]];

  // Bit area read mux, shared by coil and input reads
  always_comb begin
    bit_map = 1'b1;
    bit_rd = 1'b0;
    if (in_range(req.addr, B_HAS_LO, B_HAS_HI)) begin
      bit_rd = stat.has_mod[req.addr[2:0] - 3'h2];
    end else if (req.addr == B_MOD_OK) begin
      bit_rd = ~|stat.mod_err;
    end else if (in_range(req.addr, B_MOD_LO, B_MOD_HI)) begin
      bit_rd = stat.mod_err[4'(req.addr - B_MOD_LO)];
    end else if (req.addr == B_KIN_OK) begin
      bit_rd = ~|stat.kin_err;
    end else if (in_range(req.addr, B_KIN_LO, B_KIN_HI)) begin
      bit_rd = stat.kin_err[3'(req.addr - B_KIN_LO)];
    end else if (in_range(req.addr, B_MOD_OK, B_BLK_HI)) begin
      bit_rd = 1'b0; // Reserved error bits
    end else if (req.addr == C_BUS) begin
      bit_rd = stat.bus_conn;
    end else if (req.addr == C_SHUTDOWN || req.addr == C_RESET) begin
      bit_rd = last[edge_idx(req.addr)];
    end else if (req.addr == C_MOTOR) begin
      bit_rd = stat.motors_on;
    end else if (req.addr == B_NORMAL) begin
      bit_rd = stat.normal_op;
    end else if (req.addr == C_REF_ALL) begin
      bit_rd = stat.ref_all;
    end else if (in_range(req.addr, C_REF_AX_LO, C_REF_AX_HI)) begin
      bit_rd = stat.ref_axis[3'(req.addr - C_REF_AX_LO)];
    end else if (in_range(req.addr, C_REF_EX_LO, C_REF_EX_HI)) begin
      bit_rd = stat.ref_ext[2'(req.addr - C_REF_EX_LO)];
    end else begin
      bit_map = 1'b0; // Unmapped bit
    end
  end

  // Writable coils and the value written
  always_comb begin
    coil_wr_ok = (req.addr == C_BUS && BUS_SWITCH)
      || req.addr == C_SHUTDOWN || req.addr == C_RESET
      || req.addr == C_MOTOR
      || in_range(req.addr, C_REF_ALL, C_REF_EX_HI);
    bval = (op == OP_WR1) ? (req.wdata == COIL_ON) : req.wdata[0];
  end

  // Request execution and response
  always_comb begin
    rsp_d = rsp_q;
    rsp_valid_d = rsp_valid_q && !rsp_ready;
    act_d = '0;
    hr_d = hr_q;
    edge_wr = '0;
    if (take) begin
      rsp_valid_d = 1'b1;
      rsp_d = '0;
      if (!fc_ok) begin
        rsp_d.exc = 1'b1;
        rsp_d.exc_code = EXC_FUNC;
      end else begin
        unique case (area)
          AREA_COIL, AREA_DI: begin
            if (!bit_map) begin
              rsp_d.exc = 1'b1;
              rsp_d.exc_code = EXC_ADDR;
            end else if (op == OP_READ) begin
              rsp_d.rdata = {15'h0000, bit_rd};
            end else if (op == OP_WR1 && req.wdata != COIL_ON
                         && req.wdata != COIL_OFF) begin
              rsp_d.exc = 1'b1;
              rsp_d.exc_code = EXC_VALUE;
            end else if (!coil_wr_ok) begin
              rsp_d.exc = 1'b1;
              rsp_d.exc_code = EXC_ADDR;
            end else begin
              rsp_d.rdata = req.wdata;
              if (req.addr == C_BUS) begin
                act_d.bus_connect = bval && !stat.bus_conn;
                act_d.bus_disconnect = !bval && stat.bus_conn;
              end else if (req.addr == C_MOTOR) begin
                act_d.motor_enable = bval && !stat.motors_on;
                act_d.motor_disable = !bval && stat.motors_on;
              end else begin
                edge_wr[edge_idx(req.addr)] = 1'b1;
              end
            end
          end
          AREA_HR: begin
            if (req.addr >= HR_LIMIT) begin
              rsp_d.exc = 1'b1;
              rsp_d.exc_code = EXC_ADDR;
            end else begin
              unique case (op)
                OP_READ: rsp_d.rdata = hr_cur;
                OP_WR1, OP_WRN: begin
                  hr_d[req.addr[3:0]] = req.wdata;
                  rsp_d.rdata = req.wdata;
                end
                OP_MASK: begin
                  hr_d[req.addr[3:0]] = (hr_cur & req.and_mask)
                    | (req.or_mask & ~req.and_mask);
                  rsp_d.rdata = req.wdata;
                end
                OP_RW: begin
                  hr_d[req.addr[3:0]] = req.wdata;
                  rsp_d.rdata = req.wdata;
                end
              endcase
            end
          end
          AREA_IR: begin
            if (req.addr == IR_MAP_VER) begin
              rsp_d.rdata = MAP_VERSION;
            end else begin
              rsp_d.exc = 1'b1;
              rsp_d.exc_code = EXC_ADDR;
            end
          end
          AREA_NONE: begin
            rsp_d.exc = 1'b1;
            rsp_d.exc_code = EXC_FUNC;
          end
        endcase
      end
    end
  end

  // String length: low byte first, stops at zero byte or field end
  always_comb begin
    logic done;
    done = 1'b0;
    str_len_d = 5'h00;
    for (int i = 0; i < 2 * STR_REGS; i++) begin
      if (!done) begin
        if (hr_q[STR_BASE + i / 2][8 * (i % 2) +: 8] == 8'h00) begin
          done = 1'b1;
        end else begin
          str_len_d = str_len_d + 5'h01;
        end
      end
    end
  end

  // Server configuration
  always_comb begin
    port_d = cfg_wr ? cfg_port : port_q;
    conn_d = cfg_wr ? cfg_max_conn : conn_q;
  end

  // All registers of the decoder except the edge-coil registers in u_edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rsp_q <= '0;
      rsp_valid_q <= 1'b0;
      act_q <= '0;
      hr_q <= '0;
      str_len_q <= 5'h00;
      port_q <= TCP_PORT_DEF;
      conn_q <= MAX_CONN_DEF;
    end else begin
      rsp_q <= rsp_d;
      rsp_valid_q <= rsp_valid_d;
      act_q <= act_d;
      hr_q <= hr_d;
      str_len_q <= str_len_d;
      port_q <= port_d;
      conn_q <= conn_d;
    end
  end

  // Pair words into 32-bit values, lower register holds low half
  for (genvar k = 0; k < HR_DEPTH / 2; k++) begin : g_pair
    assign hr_pairs[k] = {hr_q[2 * k + 1], hr_q[2 * k]};
  end

  // Output routing
  always_comb begin
    act = act_q;
    act.shutdown = fire[E_SHUTDOWN];
    act.robot_reset = fire[E_RESET];
    act.ref_all = fire[E_REF_ALL];
    act.ref_axis = fire[E_REF_AX +: 6];
    act.ref_ext = fire[E_REF_EX +: 3];
  end
  assign rsp = rsp_q;
  assign rsp_valid = rsp_valid_q;
  assign hr_words = hr_q;
  assign str_len = str_len_q;
  assign tcp_port = port_q;
  assign max_conn = conn_q;

  // Version read answers 1
  property p_ver;
    @(posedge clock) disable iff (!rst_n)
    take && req.fc == FC_RD_IR && req.addr == IR_MAP_VER
      |=> rsp_valid && !rsp.exc && rsp.rdata == 16'h0001;
  endproperty
  a_ver: assert property (p_ver) else $error("bad version read");

  // Unknown codes give the illegal-function answer
  property p_badfc;
    @(posedge clock) disable iff (!rst_n)
    take && !fc_ok |=> rsp.exc && rsp.exc_code == 8'h01;
  endproperty
  a_badfc: assert property (p_badfc) else $error("no func exc");

  // Writes to information bits are refused
  property p_ro;
    @(posedge clock) disable iff (!rst_n)
    take && req.fc == FC_WR_COILS && in_range(req.addr, B_HAS_LO, B_NORMAL)
      && req.addr != C_MOTOR && req.addr != C_SHUTDOWN
      && req.addr != C_RESET && req.addr != C_BUS
      |=> rsp.exc && rsp.exc_code == 8'h02 && act == '0;
  endproperty
  a_ro: assert property (p_ro) else $error("info bit written");

  // Motor enable only from an inactive state after a written 1
  property p_motor;
    @(posedge clock) disable iff (!rst_n)
    act.motor_enable |-> $past(take) && $past(req.addr) == C_MOTOR
      && $past(bval) && !$past(stat.motors_on);
  endproperty
  a_motor: assert property (p_motor) else $error("bad enable");

  // Shutdown fires only on a written 1
  property p_edge;
    @(posedge clock) disable iff (!rst_n)
    act.shutdown |-> $past(take) && $past(req.addr) == C_SHUTDOWN
      && $past(bval);
  endproperty
  a_edge: assert property (p_edge) else $error("bad shutdown");

  // Two ones in a row never fire twice
  property p_once;
    @(posedge clock) disable iff (!rst_n)
    act.robot_reset ##1 (take && req.addr == C_RESET && bval
      && op != OP_READ && area == AREA_COIL) |=> !act.robot_reset;
  endproperty
  a_once: assert property (p_once) else $error("reset refired");

  // Single register write lands in the store
  property p_hr;
    @(posedge clock) disable iff (!rst_n)
    take && req.fc == FC_WR_HR && req.addr < HR_LIMIT
      |=> hr_q[$past(req.addr[3:0])] == $past(req.wdata);
  endproperty
  a_hr: assert property (p_hr) else $error("hr not written");

  // Module-ok bit reflects absence of errors
  property p_modok;
    @(posedge clock) disable iff (!rst_n)
    take && req.fc == FC_RD_DI && req.addr == B_MOD_OK
      |=> rsp.rdata[0] == ~|$past(stat.mod_err);
  endproperty
  a_modok: assert property (p_modok) else $error("bad module ok");
endmodule : mra_top
`default_nettype wire

// ### dv/mra_client.sv
// Client model: issues one item request and collects its answer.
// Assumes the decoder answers in the cycle after it takes a request.
`default_nettype none
module mra_client (
  input wire logic clock,             // System clock
  input wire logic req_ready,         // Request taken
  input wire logic rsp_valid,         // Response present
  input wire mra_pkg::mra_rsp_t rsp,  // Response
  input wire mra_pkg::mra_act_t act,  // Action pulses
  output logic req_valid,             // Request present
  output mra_pkg::mra_req_t req,      // Request item
  output logic rsp_ready              // Answers always consumed
);
  timeunit 1ns;
  timeprecision 1ns;
  import mra_pkg::*;
  // Idle request lines at time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
    rsp_ready = 1'b1;
  end
  // Hold the item until taken, release it, then fetch the answer
  task automatic send(input mra_req_t r, output mra_rsp_t o,
                      output mra_act_t a, output logic ok);
    int n;
    logic rdy;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= r;
    do begin
      @(negedge clock);
      rdy = req_ready;
      @(posedge clock);
      n++;
    end while (!rdy && n < 20);
    req_valid <= 1'b0;
    req <= ~r; // Released lines do not keep the old item
    @(negedge clock);
    o = rsp;
    a = act;
    ok = rdy && rsp_valid;
  endtask : send
endmodule : mra_client
`default_nettype wire

// ### dv/modbus_robot_address_map_tb_top.sv
// Self-checking bench of the robot address-map decoder.
// Assumes the client model and the design package are compiled first.
`default_nettype none
module modbus_robot_address_map_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mra_pkg::*;
  typedef struct packed {
    logic [7:0] fc; // Function code
    logic [15:0] a; // Item address
    logic [15:0] w; // Write value
    logic [7:0] c;  // Exception code, zero for none
    logic [15:0] d; // Expected read or echo
    logic b;        // Bit read: also checked through the other bit area
  } mra_row_t;
  localparam mra_row_t ROWS [20] = '{
    '{8'h01, 16'h000a, 16'h0, 8'h0, 16'h1, 1'b1},
    '{8'h02, 16'h000e, 16'h0, 8'h0, 16'h1, 1'b1},
    '{8'h01, 16'h0014, 16'h0, 8'h0, 16'h1, 1'b1},
    '{8'h02, 16'h001f, 16'h0, 8'h0, 16'h0, 1'b1},
    '{8'h01, 16'h0025, 16'h0, 8'h0, 16'h0, 1'b1},
    '{8'h02, 16'h0026, 16'h0, 8'h0, 16'h1, 1'b1},
    '{8'h01, 16'h0036, 16'h0, 8'h0, 16'h1, 1'b1},
    '{8'h04, 16'h0003, 16'h0, 8'h0, 16'h1, 1'b0},
    '{8'h04, 16'h0004, 16'h0, 8'h2, 16'h0, 1'b0},
    '{8'h01, 16'h000f, 16'h0, 8'h2, 16'h0, 1'b0},
    '{8'h05, 16'h000a, 16'hff00, 8'h2, 16'h0, 1'b0},
    '{8'h0f, 16'h0014, 16'h0001, 8'h2, 16'h0, 1'b0},
    '{8'h08, 16'h0000, 16'h0, 8'h1, 16'h0, 1'b0},
    '{8'h05, 16'h0035, 16'h1234, 8'h3, 16'h0, 1'b0},
    '{8'h06, 16'h0010, 16'h0, 8'h2, 16'h0, 1'b0},
    '{8'h06, 16'h0005, 16'ha5a5, 8'h0, 16'ha5a5, 1'b0},
    '{8'h16, 16'h0005, 16'h0, 8'h0, 16'h0, 1'b0},
    '{8'h03, 16'h0005, 16'h0, 8'h0, 16'ha511, 1'b0},
    '{8'h10, 16'h0000, 16'h5678, 8'h0, 16'h5678, 1'b0},
    '{8'h17, 16'h0001, 16'h9abc, 8'h0, 16'h9abc, 1'b0}
  };
  logic clock, rst_n, req_valid, req_ready, rsp_valid, rsp_ready, cfg_wr;
  mra_req_t req;       // Request to the decoder
  mra_rsp_t rsp, o;    // Response, last answer seen
  mra_stat_t stat;     // Live robot state
  mra_act_t act, a;    // Action pulses, last pulses seen
  logic [7:0][31:0] hr_pairs; // Holding pairs
  logic [15:0][15:0] hr_words; // Holding store
  logic [4:0] str_len; // String length
  logic [15:0] cfg_port, tcp_port;
  logic [7:0] cfg_max_conn, max_conn;
  int fails = 0;
  int cmp_count = 0;
  mra_top dut (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp(rsp), .stat(stat), .act(act),
    .hr_words(hr_words), .hr_pairs(hr_pairs), .str_len(str_len),
    .cfg_wr(cfg_wr),
    .cfg_port(cfg_port), .cfg_max_conn(cfg_max_conn),
    .tcp_port(tcp_port), .max_conn(max_conn));
  mra_client cli (.clock(clock), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .act(act), .req_valid(req_valid),
    .req(req), .rsp_ready(rsp_ready));
  task automatic chk_val(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk_val
  task automatic chk_rsp(string n, mra_rsp_t e, mra_rsp_t g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk_rsp
  // One item access with fixed masks for the masked write
  task automatic go(logic [7:0] fc, logic [15:0] ad, logic [15:0] w);
    logic ok;
    cli.send('{fc, ad, w, 16'hff00, 16'h0011}, o, a, ok);
    chk_val("taken", 32'h1, {31'h0, ok});
  endtask : go
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // Free-running 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Cuts a hang short
  initial begin
    #(50 * 4000);
    fails++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    cfg_wr = 1'b0;
    cfg_port = 16'h1234;
    cfg_max_conn = 8'h08;
    stat = '0;
    stat.has_mod = 5'h1f;
    stat.kin_err = 7'h7f;
    stat.normal_op = 1'b1;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    chk_val("port", 32'h01f6, {16'h0, tcp_port});
    chk_val("conn", 32'h4, {24'h0, max_conn});
    chk_val("rsp_valid", 32'h0, {31'h0, rsp_valid});
    cfg_wr <= 1'b1;
    @(posedge clock);
    cfg_wr <= 1'b0;
    @(negedge clock);
    chk_val("port_new", 32'h1234, {16'h0, tcp_port});
    chk_val("conn_new", 32'h8, {24'h0, max_conn});
    foreach (ROWS[i]) begin
      go(ROWS[i].fc, ROWS[i].a, ROWS[i].w);
      chk_rsp("row", {ROWS[i].c != 8'h0, ROWS[i].c, ROWS[i].d}, o);
      // Bit items read the same through the other bit area
      if (ROWS[i].b) begin
        go(ROWS[i].fc ^ 8'h03, ROWS[i].a, ROWS[i].w);
        chk_rsp("alias", {1'b0, 8'h00, ROWS[i].d}, o);
      end
    end
    chk_val("pair", 32'h9abc5678, hr_pairs[0]);
    chk_val("hr5", 32'ha511, {16'h0, hr_words[5]});
    $display("test table done");
    go(8'h05, 16'h0034, 16'hff00);
    chk_val("no_arm", 32'h0, {31'h0, a.robot_reset});
    go(8'h05, 16'h0034, 16'h0000);
    go(8'h05, 16'h0034, 16'hff00);
    chk_val("robot_reset", 32'h1, {31'h0, a.robot_reset});
    go(8'h05, 16'h0034, 16'hff00);
    chk_val("no_refire", 32'h0, {31'h0, a.robot_reset});
    go(8'h01, 16'h0034, 16'h0000);
    chk_val("reset_rb", 32'h1, {31'h0, o.rdata[0]});
    go(8'h0f, 16'h0033, 16'h0000);
    go(8'h0f, 16'h0033, 16'h0001);
    chk_val("shutdown", 32'h1, {31'h0, a.shutdown});
    go(8'h05, 16'h003c, 16'h0000);
    go(8'h05, 16'h003c, 16'hff00);
    chk_val("ref_all", 32'h1, {31'h0, a.ref_all});
    go(8'h05, 16'h0035, 16'h0000);
    chk_val("motor_idle", 32'h0, {31'h0, a.motor_disable});
    go(8'h05, 16'h0035, 16'hff00);
    chk_val("motor_on", 32'h1, {31'h0, a.motor_enable});
    @(posedge clock);
    stat.motors_on <= 1'b1;
    go(8'h01, 16'h0035, 16'h0000);
    chk_val("motor_live", 32'h1, {31'h0, o.rdata[0]});
    go(8'h05, 16'h0035, 16'h0000);
    chk_val("motor_off", 32'h1, {31'h0, a.motor_disable});
    go(8'h05, 16'h0032, 16'hff00);
    chk_val("bus", 32'h1, {31'h0, a.bus_connect});
    go(8'h06, 16'h0008, 16'h4241);
    go(8'h06, 16'h0009, 16'h0043);
    repeat (2) @(negedge clock);
    chk_val("str_len", 32'h3, {27'h0, str_len});
    go(8'h05, 16'h003d, 16'h0000);
    $display("test actions done");
    // Mid-run reset restores defaults and disarms the armed axis coil
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk_val("port_rst", 32'h01f6, {16'h0, tcp_port});
    chk_val("str_rst", 32'h0, {27'h0, str_len});
    chk_val("hr_rst", 32'h0, {16'h0, hr_words[8]});
    go(8'h05, 16'h003d, 16'hff00);
    chk_val("disarmed", 32'h0, {26'h0, a.ref_axis});
    go(8'h05, 16'h003d, 16'h0000);
    go(8'h05, 16'h003d, 16'hff00);
    chk_val("ref_axis", 32'h1, {26'h0, a.ref_axis});
    $display("test reset done");
    stop_test();
  end
endmodule : modbus_robot_address_map_tb_top
`default_nettype wire
